// File: mam_monitor_regs.v
/*
  register bank slice: shutdown control, alert masking and extended
  resolution readout with read freeze. assumes a simple synchronous
  register port driven by the smbus host engine, one access per strobe.
*/
`timescale 1ns/1ps
`include "mam_consts.vh"

module mam_monitor_regs
(
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata_q,
  input  wire        config_lock,
  input  wire [7:0]  flags_vt,
  input  wire [7:0]  flags_fd,
  input  wire        status2_any,
  input  wire        overtemp_mask_in,
  input  wire        fourth_speed_input,
  input  wire        thermal_limit_pin,
  input  wire [39:0] volt_results,
  input  wire        results_valid,
  input  wire [23:0] duty_live,
  input  wire [2:0]  pwm_raw,
  input  wire        output_polarity_flip,
  output reg  [2:0]  pwm_out_q,
  output reg         power_down_ctl_q,
  output reg         one_channel_mode_bit_q,
  output reg  [2:0]  chan_sel_q,
  output reg         alert_n_q
);

  // --------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------
  reg  [7:0]  second_config_q;
  reg  [7:0]  mask_vt_q;
  reg  [7:0]  mask_fd_q;
  reg  [7:0]  fan_one_fault_mask_min_hi_q;
  reg  [39:0] volt_hold_q;
  reg  [3:0]  frozen_q;
  reg  [7:0]  rd_d;
  wire        alert_req;
  wire [7:0]  mask_fd_eff;
  wire [7:0]  low_bits;
  wire        frz_any = |frozen_q;
  integer     k;

  // --------------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------------
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      second_config_q <= `MAM_RST_SECOND_CONFIG;
      mask_vt_q       <= `MAM_RST_MASK;
      mask_fd_q       <= `MAM_RST_MASK;
      fan_one_fault_mask_min_hi_q   <= `MAM_RST_FAN_ONE_FAULT_MASK_MIN_HI;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `MAM_ADDR_SECOND_CONFIG:
          if (!config_lock)
            second_config_q <= reg_wdata;
        `MAM_ADDR_MASK_VT:
          mask_vt_q <= reg_wdata;
        `MAM_ADDR_MASK_FD:
          mask_fd_q <= reg_wdata;
        `MAM_ADDR_FAN_ONE_FAULT_MASK_MIN_HI:
          fan_one_fault_mask_min_hi_q <= reg_wdata;
        default:
          ;
      endcase
    end
  end

  // overtemp mask bit is not software writable; it tracks its source
  assign mask_fd_eff = {mask_fd_q[7:2], overtemp_mask_in, mask_fd_q[0]};

  // --------------------------------------------------------------------
  // result capture with read freeze
  // --------------------------------------------------------------------
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      volt_hold_q <= 40'h00_0000_0000;
      frozen_q    <= 4'h0;
    end
    else
    begin
      if (results_valid && !frz_any)
        volt_hold_q <= volt_results;
      if (reg_rd && reg_addr == `MAM_ADDR_VOLT_LOW)
        frozen_q <= 4'hF;
      else if (reg_rd)
      begin
        for (k = 0; k < 4; k = k + 1)
          if (reg_addr == `MAM_ADDR_V25_HI + k[7:0])
            frozen_q[k] <= 1'b0;
      end
    end
  end

  // each 10-bit reading: bits [9:2] high byte, [1:0] low bits
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_low
      assign low_bits[2*g+1:2*g] = volt_hold_q[10*g+1:10*g];
    end
  endgenerate

  // --------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------
  always @*
  begin
    rd_d = 8'h00;
    case (reg_addr)
      `MAM_ADDR_SECOND_CONFIG: rd_d = second_config_q;
      `MAM_ADDR_MASK_VT:       rd_d = mask_vt_q;
      `MAM_ADDR_MASK_FD:       rd_d = mask_fd_eff;
      `MAM_ADDR_VOLT_LOW:      rd_d = low_bits;
      `MAM_ADDR_FAN_ONE_FAULT_MASK_MIN_HI:   rd_d = fan_one_fault_mask_min_hi_q;
      `MAM_ADDR_V25_HI:        rd_d = volt_hold_q[9:2];
      `MAM_ADDR_VCORE_HI:      rd_d = volt_hold_q[19:12];
      `MAM_ADDR_VMAIN_HI:      rd_d = volt_hold_q[29:22];
      `MAM_ADDR_V5_HI:         rd_d = volt_hold_q[39:32];
      `MAM_ADDR_DUTY1:
        rd_d = second_config_q[`MAM_CFG2_POWER_DOWN_BIT] ? `MAM_DUTY_OFF : duty_live[7:0];
      `MAM_ADDR_DUTY2:
        rd_d = second_config_q[`MAM_CFG2_POWER_DOWN_BIT] ? `MAM_DUTY_OFF : duty_live[15:8];
      `MAM_ADDR_DUTY3:
        rd_d = second_config_q[`MAM_CFG2_POWER_DOWN_BIT] ? `MAM_DUTY_OFF : duty_live[23:16];
      default:                 rd_d = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------
  // alert gating
  // --------------------------------------------------------------------
  mam_alert_gate u_gate
  (
    .ref_clk     (ref_clk),
    .nrst        (nrst),
    .flags_vt    (flags_vt),
    .flags_fd    (flags_fd),
    .mask_vt     (mask_vt_q),
    .mask_fd     (mask_fd_eff),
    .status2_any (status2_any),
    .alert_q     (alert_req)
  );

  // --------------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------------
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata_q            <= 8'h00;
      pwm_out_q              <= 3'b000;
      power_down_ctl_q       <= 1'b0;
      one_channel_mode_bit_q <= 1'b0;
      chan_sel_q             <= 3'b000;
      alert_n_q              <= 1'b1;
    end
    else
    begin
      reg_rdata_q <= rd_d;
      if (second_config_q[`MAM_CFG2_POWER_DOWN_BIT])
        pwm_out_q <= {3{output_polarity_flip}};
      else
        pwm_out_q <= pwm_raw;
      power_down_ctl_q       <= second_config_q[`MAM_CFG2_POWER_DOWN_BIT];
      one_channel_mode_bit_q <= second_config_q[`MAM_CFG2_ONE_CHAN_BIT];
      chan_sel_q             <= fan_one_fault_mask_min_hi_q[`MAM_CHAN_SEL_MSB:`MAM_CHAN_SEL_LSB];
      alert_n_q              <= ~alert_req;
    end
  end

endmodule

// File: mam_consts.vh
/*
  register offsets, field positions and reset values for the monitor
  alert-mask and readout block. assumes it is included by bare name.
*/
`ifndef MAM_CONSTS_VH
`define MAM_CONSTS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define MAM_ADDR_SECOND_CONFIG   8'h73
`define MAM_ADDR_MASK_VT         8'h74
`define MAM_ADDR_MASK_FD         8'h75
`define MAM_ADDR_VOLT_LOW        8'h76
`define MAM_ADDR_FAN_ONE_FAULT_MASK_MIN_HI     8'h55
`define MAM_ADDR_V25_HI          8'h20
`define MAM_ADDR_VCORE_HI        8'h21
`define MAM_ADDR_VMAIN_HI        8'h22
`define MAM_ADDR_V5_HI           8'h23
`define MAM_ADDR_DUTY1           8'h30
`define MAM_ADDR_DUTY2           8'h31
`define MAM_ADDR_DUTY3           8'h32

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MAM_CFG2_ONE_CHAN_BIT    6
`define MAM_CFG2_POWER_DOWN_BIT  7
`define MAM_MASK2_OVERTEMP_BIT   1
`define MAM_MASK1_GROUP_BIT      7
`define MAM_CHAN_SEL_MSB         7
`define MAM_CHAN_SEL_LSB         5

// ----------------------------------------------------------------------
// reset values and shutdown duty readback
// ----------------------------------------------------------------------
`define MAM_RST_SECOND_CONFIG    8'h00
`define MAM_RST_MASK             8'h00
`define MAM_RST_FAN_ONE_FAULT_MASK_MIN_HI      8'hFF
`define MAM_DUTY_OFF             8'h00

`endif

// File: mam_alert_gate.v
/*
  combines event flags with mask bits into one registered alert request.
  assumes flags and masks are synchronous to ref_clk.
*/
`timescale 1ns/1ps

module mam_alert_gate
(
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire [7:0]  flags_vt,
  input  wire [7:0]  flags_fd,
  input  wire [7:0]  mask_vt,
  input  wire [7:0]  mask_fd,
  input  wire        status2_any,
  output reg         alert_q
);

  // --------------------------------------------------------------------
  // per-bit gating
  // --------------------------------------------------------------------
  wire [6:0] live_vt;
  wire [7:0] live_fd;
  genvar     i;

  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_fd
      assign live_fd[i] = flags_fd[i] & ~mask_fd[i];
      if (i < 7)
      begin : g_vt
        assign live_vt[i] = flags_vt[i] & ~mask_vt[i];
      end
    end
  endgenerate

  wire group_live = status2_any & ~mask_vt[7];

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      alert_q <= 1'b0;
    else
      alert_q <= (|live_vt) | (|live_fd) | group_live;
  end

endmodule

// File: mam_checker.sv
/*
  concurrent checks on the monitor alert-mask and readout block.
  assumes it is bound to mam_monitor_regs and sees only its ports.
*/
`timescale 1ns/1ps

module mam_checker
(
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       config_lock,
  input wire logic [7:0] flags_vt,
  input wire logic [7:0] flags_fd,
  input wire logic       status2_any,
  input wire logic       output_polarity_flip,
  input wire logic [2:0] pwm_out_q,
  input wire logic       power_down_ctl_q,
  input wire logic       one_channel_mode_bit_q,
  input wire logic [2:0] chan_sel_q,
  input wire logic       alert_n_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  power_down_ctl_pwm_a:
    assert property (power_down_ctl_q |-> pwm_out_q == {3{$past(output_polarity_flip)}})
    else $error("pwm not at fans-off level");
  duty_zero_a:
    assert property (power_down_ctl_q && $past(reg_addr) inside {8'h30, 8'h31, 8'h32} |-> reg_rdata_q == 8'h00)
    else $error("duty read not zero in shutdown");
  cfg_lock_a:
    assert property ($past(config_lock, 2) && $past(config_lock) |-> $stable({power_down_ctl_q, one_channel_mode_bit_q}))
    else $error("locked config changed");
  cfg_write_a:
    assert property (reg_wr && reg_addr == 8'h73 && !config_lock |-> ##2
      {power_down_ctl_q, one_channel_mode_bit_q} == $past(reg_wdata[7:6], 2))
    else $error("config write not applied");
  chan_sel_a:
    assert property (reg_wr && reg_addr == 8'h55 |-> ##2 chan_sel_q == $past(reg_wdata[7:5], 2))
    else $error("channel select wrong");
  mask1_rw_a:
    assert property (reg_wr && reg_addr == 8'h74 ##1 reg_addr == 8'h74 |=> reg_rdata_q == $past(reg_wdata, 2))
    else $error("mask one readback wrong");
  mask2_rw_a:
    assert property (reg_wr && reg_addr == 8'h75 ##1 reg_addr == 8'h75 |=>
      {reg_rdata_q[7:2], reg_rdata_q[0]} == {$past(reg_wdata[7:2], 2), $past(reg_wdata[0], 2)})
    else $error("mask two readback wrong");
  freeze_hold_a:
    assert property (reg_rd && reg_addr == 8'h76 ##1 reg_addr == 8'h76 [*4] |-> $stable(reg_rdata_q))
    else $error("frozen low bits changed");
  alert_cause_a:
    assert property (!alert_n_q |-> $past(status2_any, 2) || ($past(flags_vt, 2) | $past(flags_fd, 2)) != 8'h00)
    else $error("alert without event");
endmodule

bind mam_monitor_regs mam_checker u_mam_checker (.*);

// File: mam_host.sv
/*
  register host model issuing single-cycle write and read strobes.
  assumes the block answers reads one cycle after the strobe edge.
*/
`timescale 1ns/1ps

module mam_host
(
  input  wire logic       ref_clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata_q
);
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0_0000;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge ref_clk) #1;
    reg_wr    = 1'b0;
  endtask

  // high bytes are read after the low-bit register to release the freeze
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk) #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge ref_clk) #1;
    reg_rd   = 1'b0;
    d        = reg_rdata_q;
  endtask
endmodule

// File: tb.sv
/*
  self-checking bench for mam_monitor_regs.
  assumes mam_host and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps

module tb;
  logic        ref_clk = 0, nrst = 0, config_lock = 0, status2_any = 0, overtemp_mask_in = 0;
  logic        fourth_speed_input = 0, thermal_limit_pin = 0, results_valid = 0, output_polarity_flip = 0;
  logic        reg_wr, reg_rd, power_down_ctl_q, one_channel_mode_bit_q, alert_n_q;
  logic [7:0]  flags_vt = 0, flags_fd = 0, reg_addr, reg_wdata, reg_rdata_q;
  logic [39:0] volt_results = 0;
  logic [23:0] duty_live = {8'h33, 8'h22, 8'h11};
  logic [2:0]  pwm_raw = 3'h5, pwm_out_q, chan_sel_q;
  int          n_fail = 0, n_tests = 0;

  mam_monitor_regs u_mam_monitor_regs (.*);
  mam_host u_mam_host (.*);

  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic t_reset;
    logic [39:0] t;
    logic [7:0]  d;
    t = {8'h73, 8'h74, 8'h75, 8'h7f, 8'h55};
    for (int k = 0; k < 5; k++)
    begin
      u_mam_host.rd(t[k*8 +: 8], d);
      chk(d, (k == 0) ? 8'hff : 8'h00);
    end
    u_mam_host.wr(8'h75, 8'h02);
    u_mam_host.rd(8'h75, d);
    chk(d, 8'h00);
    $display("reset test done");
  endtask

  task automatic t_mask;
    logic [7:0] m, a, d;
    for (int i = 0; i < 16; i++)
    begin
      m = 8'h01 << i[2:0];
      a = (i < 8) ? 8'h74 : 8'h75;
      overtemp_mask_in = (i == 9);
      u_mam_host.wr(a, m);
      u_mam_host.rd(a, d);
      chk(d, m);
      if (i == 7) status2_any = 1'b1;
      else if (i < 8) flags_vt = m;
      else flags_fd = m;
      step(3);
      chk(alert_n_q, 8'h01);
      overtemp_mask_in = 1'b0;
      u_mam_host.wr(a, 8'h00);
      step(3);
      chk(alert_n_q, 8'h00);
      {flags_vt, flags_fd, status2_any} = 17'h0_0000;
      step(3);
    end
    $display("mask test done");
  endtask

  task automatic t_power_down_ctl;
    logic [7:0] d;
    u_mam_host.wr(8'h73, 8'h80);
    step(2);
    chk(pwm_out_q, 8'h00);
    output_polarity_flip = 1'b1;
    step(2);
    chk(pwm_out_q, 8'h07);
    for (int j = 0; j < 3; j++)
    begin
      u_mam_host.rd(8'h30 + j[7:0], d);
      chk(d, 8'h00);
    end
    output_polarity_flip = 1'b0;
    u_mam_host.wr(8'h73, 8'h00);
    u_mam_host.rd(8'h31, d);
    chk(d, 8'h22);
    chk(pwm_out_q, 8'h05);
    $display("shutdown test done");
  endtask

  task automatic t_lock;
    logic [7:0] d;
    u_mam_host.wr(8'h73, 8'h40);
    config_lock = 1'b1;
    u_mam_host.wr(8'h73, 8'h80);
    u_mam_host.rd(8'h73, d);
    chk(d, 8'h40);
    chk(one_channel_mode_bit_q, 8'h01);
    chk(power_down_ctl_q, 8'h00);
    config_lock = 1'b0;
    for (int c = 0; c < 8; c++)
    begin
      u_mam_host.wr(8'h55, {c[2:0], 5'h00});
      step(2);
      chk(chan_sel_q, c[2:0]);
    end
    u_mam_host.wr(8'h73, 8'h00);
    $display("lock test done");
  endtask

  task automatic t_freeze;
    logic [39:0] a, b;
    logic [7:0]  d;
    a = {10'h3c1, 10'h2a2, 10'h155, 10'h0e7};
    b = ~a;
    volt_results = a;
    results_valid = 1'b1;
    step(1);
    results_valid = 1'b0;
    u_mam_host.rd(8'h76, d);
    chk(d, {a[31:30], a[21:20], a[11:10], a[1:0]});
    volt_results = b;
    results_valid = 1'b1;
    step(1);
    results_valid = 1'b0;
    step(3);
    u_mam_host.rd(8'h76, d);
    chk(d, {a[31:30], a[21:20], a[11:10], a[1:0]});
    for (int j = 0; j < 4; j++)
    begin
      u_mam_host.rd(8'h20 + j[7:0], d);
      chk(d, a[j*10+2 +: 8]);
    end
    results_valid = 1'b1;
    step(1);
    results_valid = 1'b0;
    u_mam_host.rd(8'h76, d);
    chk(d, {b[31:30], b[21:20], b[11:10], b[1:0]});
    $display("freeze test done");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    step(10);
    nrst = 1'b1;
    t_reset;
    t_mask;
    t_power_down_ctl;
    t_lock;
    t_freeze;
    print_verdict;
  end

  initial
  begin
    #(25 * 20000);
    n_fail++;
    print_verdict;
  end
endmodule
